// >>> rtl/dubp_pkg.sv
// Constants and types for the dual serial bridge pin control block.
// Assumes a 25 MHz core clock and a byte-addressed Avalon-MM slave.
package dubp_pkg;

    ////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int TOGGLE_HALF_NS = 50_000_000;
    localparam int TOGGLE_DIV     = TOGGLE_HALF_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////
    // Sizes and watermarks
    localparam int NPINS = 5;
    localparam int LVL_W = 9;
    localparam logic [LVL_W-1:0] ENH_RX_WM = 9'h0BF;
    localparam logic [LVL_W-1:0] STD_RX_WM = 9'h03F;
    localparam logic [1:0]       CTS_MAX_BYTES = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CFG      = 8'h00;
    localparam logic [7:0] ADDR_LATCH    = 8'h04;
    localparam logic [7:0] ADDR_PINS     = 8'h08;
    localparam logic [7:0] ADDR_CTRL     = 8'h0C;
    localparam logic [7:0] ADDR_OTP_BASE = 8'h40;
    localparam logic [7:0] ADDR_OTP_END  = 8'h80;
    localparam int         OTP_DEPTH     = 16;

    ////////////////////////////////////////////////////////////////////
    // Configuration word fields
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_ENH_MODEM = 10;
    localparam int CFG_STD_MODEM = 11;
    localparam int CFG_ENH_TXTOG = 12;
    localparam int CFG_ENH_RXTOG = 13;
    localparam int CFG_ENH_RS485 = 14;
    localparam int CFG_STD_TXTOG = 15;
    localparam int CFG_STD_RXTOG = 16;
    localparam int CFG_RS485_LOW = 17;
    localparam int CFG_NO_FLUSH  = 18;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Control word fields
    localparam int CTRL_HWFLOW_LSB = 0;
    localparam int CTRL_OPEN       = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Built-in descriptor defaults
    localparam logic [7:0]  OTP_ATTR    = 8'h80;
    localparam logic [7:0]  OTP_MAXPWR  = 8'h32;
    localparam logic [15:0] OTP_RELEASE = 16'h0100;

    ////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {PIN_IN, PIN_OD, PIN_PP} dubp_mode_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_BUSY, BUS_ACK} dubp_bus_e;

endpackage

// >>> rtl/dubp_otp_mem.sv
// Write-once word store for descriptor data.
// Assumes one access per cycle; read data registered, one cycle late.
`timescale 1ns/10ps
`default_nettype none
module dubp_otp_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    parameter int AW    = 4
)(
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst,
    // Access
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0]  wr_data,
    output logic      [W-1:0]  rd_data,
    output logic               rd_prog
);

    logic [W-1:0]     mem [DEPTH];
    logic [DEPTH-1:0] prog_reg;
    logic [DEPTH-1:0] prog_next;

    always_comb
    begin
        prog_next = prog_reg;
        if (wr_en)
        begin
            prog_next[addr] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prog_reg <= '0;
            rd_prog  <= 1'b0;
        end
        else
        begin
            prog_reg <= prog_next;
            rd_prog  <= prog_reg[addr];
        end
    end

    // Each word takes its first write only
    always_ff @(posedge core_clk)
    begin
        if (wr_en && !prog_reg[addr])
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end

endmodule
`default_nettype wire

// >>> rtl/dubp_pin_ctrl.sv
// Status and control pin logic of a dual serial bridge, register file
// and descriptor store. Assumes the serial cores share core_clk.
//
// Functional notes
// - Five pins: three standard, two enhanced
// - Pins act only in general-purpose mode
// - Each pin input, open-drain or push-pull
// - Alternate functions on pins 0 and 1
// - Unprogrammed pins are inputs; config writable once
// - Open-drain high only via pull-up; push-pull drives
// - Toggle pins idle high, toggle during transfer
// - Enhanced pin 1 asserted during transmit and break
// - Transceiver control active-high, optionally active-low
// - Flow control only when selected
// - Request-to-send low below watermark 191/63
// - Request-to-send high at watermark
// - At most two bytes after clear-to-send high
// - Descriptor store with built-in defaults
// - Default serial eight chars, sixteen maximum
// - Opening a port flushes all FIFOs unless CFG_NO_FLUSH is set
`timescale 1ns/10ps
`default_nettype none
module dubp_pin_ctrl
    import dubp_pkg::*;
#(
    parameter int unsigned TOG_DIV    = TOGGLE_DIV,
    parameter logic [15:0] VENDOR_ID  = 16'h5A5A, // Arbitrary value
    parameter logic [15:0] PRODUCT_ID = 16'hA5A5, // Arbitrary value
    parameter logic [63:0] SERIAL_DEF = 64'h3130_3030_3030_3030
)(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Avalon-MM slave
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // Serial core activity
    input  wire logic             enh_tx_active,
    input  wire logic             enh_rx_active,
    input  wire logic             enh_break_active,
    input  wire logic             std_tx_active,
    input  wire logic             std_rx_active,
    input  wire logic             enh_tx_byte_start,
    input  wire logic             std_tx_byte_start,
    input  wire logic [LVL_W-1:0] enh_rx_level,
    input  wire logic [LVL_W-1:0] std_rx_level,
    output logic                  enh_tx_halt,
    output logic                  std_tx_halt,
    output logic                  fifo_flush,
    // Flow control pins
    input  wire logic             enh_cts_n,
    input  wire logic             std_cts_n,
    output logic                  enh_rts_n,
    output logic                  std_rts_n,
    // General-purpose pins
    input  wire logic             enh_pin0_in,
    output logic                  enh_pin0_out,
    output logic                  enh_pin0_oe,
    input  wire logic             enh_pin1_in,
    output logic                  enh_pin1_out,
    output logic                  enh_pin1_oe,
    input  wire logic             std_pin0_in,
    output logic                  std_pin0_out,
    output logic                  std_pin0_oe,
    input  wire logic             std_pin1_in,
    output logic                  std_pin1_out,
    output logic                  std_pin1_oe,
    input  wire logic             std_pin2_in,
    output logic                  std_pin2_out,
    output logic                  std_pin2_oe
);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    dubp_bus_e        bus_reg, bus_next;
    logic             wait_reg, wait_next;
    logic [31:0]      rdata_reg, rdata_next;
    logic [31:0]      cfg_reg, cfg_next;
    logic             lock_reg, lock_next;
    logic [NPINS-1:0] latch_reg, latch_next;
    logic [1:0]       hw_reg, hw_next;
    logic             flush_reg, flush_next;
    logic [6:0]       sync1_reg, sync2_reg;
    logic [31:0]      div_reg, div_next;
    logic [3:0]       tog_reg, tog_next;
    logic             rs485_reg, rs485_next;
    logic [1:0]       rts_reg, rts_next;
    logic [1:0]       halt_reg, halt_next;
    logic [1:0]       cnt_reg [2];
    logic [1:0]       cnt_next [2];
    logic [NPINS-1:0] out_reg, out_next, oe_reg, oe_next;
    logic [NPINS-1:0] alt_sel, alt_val, modem;
    logic [NPINS-1:0] pin_s;
    logic [1:0]       cts_s;
    logic [3:0]       act;
    logic             tick, aligned, is_otp, otp_we, otp_prog;
    logic [3:0]       otp_idx;
    logic [31:0]      otp_rd, otp_word;
    logic [LVL_W-1:0] lvl [2];
    logic [LVL_W-1:0] wm [2];
    logic [1:0]       tx_start;

    ////////////////////////////////////////////////////////////////////
    // Register bus
    function automatic logic [31:0] otp_default(input logic [3:0] idx);
        case (idx)
            4'h0:    return {PRODUCT_ID, VENDOR_ID};
            4'h1:    return {OTP_RELEASE, OTP_MAXPWR, OTP_ATTR};
            4'h2:    return SERIAL_DEF[31:0];
            4'h3:    return SERIAL_DEF[63:32];
            default: return 32'h0000_0000;
        endcase
    endfunction

    assign aligned  = (avs_address[1:0] == 2'h0);
    assign is_otp   = aligned && (avs_address >= ADDR_OTP_BASE)
                      && (avs_address < ADDR_OTP_END);
    assign otp_idx  = avs_address[5:2];
    assign otp_word = otp_prog ? otp_rd : otp_default(otp_idx);

    always_comb
    begin
        bus_next   = bus_reg;
        wait_next  = 1'b1;
        rdata_next = rdata_reg;
        cfg_next   = cfg_reg;
        lock_next  = lock_reg;
        latch_next = latch_reg;
        hw_next    = hw_reg;
        flush_next = 1'b0;
        otp_we     = 1'b0;
        case (bus_reg)
            BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    bus_next = BUS_BUSY;
                end
            end
            BUS_BUSY:
            begin
                bus_next   = BUS_ACK;
                wait_next  = 1'b0;
                rdata_next = 32'h0000_0000;
                if (avs_read && is_otp)
                begin
                    rdata_next = otp_word;
                end
                else if (avs_read && aligned)
                begin
                    case (avs_address)
                        ADDR_CFG:   rdata_next = cfg_reg;
                        ADDR_LATCH: rdata_next = 32'(latch_reg);
                        ADDR_PINS:  rdata_next = {20'h0_0000, halt_reg,
                                        lock_reg, cts_s, rts_reg, pin_s};
                        ADDR_CTRL:  rdata_next = 32'(hw_reg);
                        default:    rdata_next = 32'h0000_0000;
                    endcase
                end
                else if (avs_write && is_otp)
                begin
                    otp_we = 1'b1;
                end
                else if (avs_write && aligned)
                begin
                    case (avs_address)
                        ADDR_CFG:
                        begin
                            if (!lock_reg)
                            begin
                                cfg_next  = avs_writedata;
                                lock_next = 1'b1;
                            end
                        end
                        ADDR_LATCH: latch_next = avs_writedata[NPINS-1:0];
                        ADDR_CTRL:
                        begin
                            hw_next = avs_writedata[CTRL_HWFLOW_LSB +: 2];
                            flush_next = avs_writedata[CTRL_OPEN]
                                         && !cfg_reg[CFG_NO_FLUSH];
                        end
                        default: ;
                    endcase
                end
            end
            BUS_ACK: bus_next = BUS_IDLE;
            default: bus_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_reg   <= BUS_IDLE;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            cfg_reg   <= CFG_RESET;
            lock_reg  <= 1'b0;
            latch_reg <= '0;
            hw_reg    <= CTRL_RESET;
            flush_reg <= 1'b0;
        end
        else
        begin
            bus_reg   <= bus_next;
            wait_reg  <= wait_next;
            rdata_reg <= rdata_next;
            cfg_reg   <= cfg_next;
            lock_reg  <= lock_next;
            latch_reg <= latch_next;
            hw_reg    <= hw_next;
            flush_reg <= flush_next;
        end
    end

    dubp_otp_mem #(
        .W     (32),
        .DEPTH (OTP_DEPTH),
        .AW    (4)
    ) u_otp (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (otp_we),
        .addr     (otp_idx),
        .wr_data  (avs_writedata),
        .rd_data  (otp_rd),
        .rd_prog  (otp_prog)
    );

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end
        else
        begin
            sync1_reg <= {std_cts_n, enh_cts_n, std_pin2_in, std_pin1_in,
                          std_pin0_in, enh_pin1_in, enh_pin0_in};
            sync2_reg <= sync1_reg;
        end
    end
    assign pin_s = sync2_reg[4:0];
    assign cts_s = sync2_reg[6:5];

    ////////////////////////////////////////////////////////////////////
    // Activity toggles and transceiver control
    assign act  = {std_rx_active, std_tx_active,
                   enh_rx_active, enh_tx_active};
    assign tick = (div_reg == 32'(TOG_DIV - 1));

    always_comb
    begin
        div_next = tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
        for (int k = 0; k < 4; k++)
        begin
            if (!act[k])
                tog_next[k] = 1'b1;
            else
                tog_next[k] = tog_reg[k] ^ tick;
        end
        rs485_next = (enh_tx_active || enh_break_active)
                     ^ cfg_reg[CFG_RS485_LOW];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            div_reg   <= 32'h0000_0000;
            tog_reg   <= 4'hF;
            rs485_reg <= 1'b0;
        end
        else
        begin
            div_reg   <= div_next;
            tog_reg   <= tog_next;
            rs485_reg <= rs485_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_comb
    begin
        alt_sel = {1'b0, cfg_reg[CFG_STD_RXTOG], cfg_reg[CFG_STD_TXTOG],
                   cfg_reg[CFG_ENH_RS485] | cfg_reg[CFG_ENH_RXTOG],
                   cfg_reg[CFG_ENH_TXTOG]};
        alt_val = {1'b1, tog_reg[3], tog_reg[2],
                   cfg_reg[CFG_ENH_RS485] ? rs485_reg : tog_reg[1],
                   tog_reg[0]};
        modem   = {{3{cfg_reg[CFG_STD_MODEM]}},
                   {2{cfg_reg[CFG_ENH_MODEM]}}};
    end

    generate
        for (genvar i = 0; i < NPINS; i++)
        begin : g_pin
            dubp_mode_e mode;
            logic       val;
            assign mode = dubp_mode_e'(cfg_reg[CFG_MODE_LSB + 2*i +: 2]);
            assign val  = alt_sel[i] ? alt_val[i] : latch_reg[i];

            always_comb
            begin
                out_next[i] = 1'b0;
                oe_next[i]  = 1'b0;
                if (modem[i])
                begin
                    oe_next[i] = 1'b0;
                end
                else if (mode == PIN_OD)
                begin
                    oe_next[i] = !val;
                end
                else if (mode == PIN_PP || alt_sel[i])
                begin
                    out_next[i] = val;
                    oe_next[i]  = 1'b1;
                end
            end

            a_pin_input: assert property (!modem[i] && !alt_sel[i]
                && mode != PIN_OD && mode != PIN_PP |=> !oe_reg[i])
                else $error("input pin is driven");
            a_pin_od_low: assert property (!modem[i] && mode == PIN_OD
                |=> !out_reg[i] && (oe_reg[i] == !$past(val)))
                else $error("open-drain pin drives high");
            a_pin_modem: assert property (modem[i] |=> !oe_reg[i])
                else $error("pin driven in modem mode");
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            out_reg <= '0;
            oe_reg  <= '0;
        end
        else
        begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Hardware flow control
    assign lvl      = '{enh_rx_level, std_rx_level};
    assign wm       = '{ENH_RX_WM, STD_RX_WM};
    assign tx_start = {std_tx_byte_start, enh_tx_byte_start};

    always_comb
    begin
        for (int j = 0; j < 2; j++)
        begin
            rts_next[j] = hw_reg[j] && (lvl[j] >= wm[j]);
            cnt_next[j] = cnt_reg[j];
            if (!hw_reg[j] || !cts_s[j])
                cnt_next[j] = 2'h0;
            else if (tx_start[j] && cnt_reg[j] < CTS_MAX_BYTES)
                cnt_next[j] = 2'(cnt_reg[j] + 2'h1);
            halt_next[j] = hw_reg[j] && cts_s[j]
                           && (cnt_next[j] == CTS_MAX_BYTES);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rts_reg  <= 2'h0;
            halt_reg <= 2'h0;
            cnt_reg  <= '{2'h0, 2'h0};
        end
        else
        begin
            rts_reg  <= rts_next;
            halt_reg <= halt_next;
            cnt_reg  <= cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign enh_tx_halt     = halt_reg[0];
    assign std_tx_halt     = halt_reg[1];
    assign fifo_flush      = flush_reg;
    assign enh_rts_n       = rts_reg[0];
    assign std_rts_n       = rts_reg[1];
    assign enh_pin0_out    = out_reg[0];
    assign enh_pin0_oe     = oe_reg[0];
    assign enh_pin1_out    = out_reg[1];
    assign enh_pin1_oe     = oe_reg[1];
    assign std_pin0_out    = out_reg[2];
    assign std_pin0_oe     = oe_reg[2];
    assign std_pin1_out    = out_reg[3];
    assign std_pin1_oe     = oe_reg[3];
    assign std_pin2_out    = out_reg[4];
    assign std_pin2_oe     = oe_reg[4];

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_tog_idle: assert property (!enh_tx_active |=> tog_reg[0])
        else $error("transmit toggle not idle high");
    a_rs485_lvl: assert property (enh_tx_active
        |=> rs485_reg == !$past(cfg_reg[CFG_RS485_LOW]))
        else $error("transceiver control not asserted");
    a_rts_high: assert property (hw_reg[0] && enh_rx_level >= ENH_RX_WM
        |=> enh_rts_n)
        else $error("rts not raised at watermark");
    a_rts_low: assert property (hw_reg[1] && std_rx_level < STD_RX_WM
        |=> !std_rts_n)
        else $error("rts not lowered below watermark");
    a_rts_nohw: assert property (!hw_reg[0] |=> !enh_rts_n)
        else $error("rts moved without flow control");
    a_cts_limit: assert property (halt_reg[0]
        |-> cnt_reg[0] == CTS_MAX_BYTES && $past(cts_s[0]))
        else $error("halt without two counted bytes");
    a_cfg_once: assert property (lock_reg |=> $stable(cfg_reg))
        else $error("config changed after lock");
    a_flush_open: assert property (bus_reg == BUS_BUSY && avs_write
        && avs_address == ADDR_CTRL && avs_writedata[CTRL_OPEN]
        && !cfg_reg[CFG_NO_FLUSH] |=> fifo_flush ##1 !fifo_flush)
        else $error("open did not flush once");
    a_bus_ack: assert property (bus_reg == BUS_IDLE
        && (avs_read || avs_write) |=> ##1 !avs_waitrequest)
        else $error("bus answer late");

endmodule
`default_nettype wire

// >>> test/dubp_far_model.sv
// Far side: pulled-up pins and an external UART device.
// Assumes oe high means the block drives the pin.
`timescale 1ns/10ps
`default_nettype none
module dubp_far_model (
    // Pin drive from the block
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    input  wire logic [1:0] full,
    // Levels seen by the block
    output logic      [4:0] pin_lvl,
    output logic      [1:0] cts_n
);
    assign pin_lvl = ~pin_oe | pin_out;
    assign cts_n   = full;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Directed bench for the pin control block over Avalon-MM.
// Assumes the far model resolves pins and clear-to-send.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dubp_pkg::*;
    logic        core_clk = 0;
    logic        rst = 1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 0;
    logic        avs_write = 0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire         fifo_flush;
    logic [4:0]  act = 5'h00;
    logic [1:0]  bs = 2'h0;
    logic [1:0]  full = 2'h0;
    logic [8:0]  enh_lvl = 9'h000;
    logic [8:0]  std_lvl = 9'h000;
    wire  [4:0]  po, pe, pl;
    wire  [1:0]  halt, rts_n, cts_n;
    logic [31:0] q;
    logic        prev;
    int          n;
    int          mismatches = 0;
    int          checks_done = 0;
    int          flushes = 0;

    dubp_pin_ctrl #(.TOG_DIV(4)) dut (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .fifo_flush,
        .enh_tx_active(act[0]), .enh_rx_active(act[1]),
        .enh_break_active(act[2]), .std_tx_active(act[3]),
        .std_rx_active(act[4]), .enh_tx_byte_start(bs[0]),
        .std_tx_byte_start(bs[1]), .enh_rx_level(enh_lvl),
        .std_rx_level(std_lvl), .enh_tx_halt(halt[0]),
        .std_tx_halt(halt[1]), .enh_cts_n(cts_n[0]),
        .std_cts_n(cts_n[1]), .enh_rts_n(rts_n[0]), .std_rts_n(rts_n[1]),
        .enh_pin0_in(pl[0]), .enh_pin0_out(po[0]), .enh_pin0_oe(pe[0]),
        .enh_pin1_in(pl[1]), .enh_pin1_out(po[1]), .enh_pin1_oe(pe[1]),
        .std_pin0_in(pl[2]), .std_pin0_out(po[2]), .std_pin0_oe(pe[2]),
        .std_pin1_in(pl[3]), .std_pin1_out(po[3]), .std_pin1_oe(pe[3]),
        .std_pin2_in(pl[4]), .std_pin2_out(po[4]), .std_pin2_oe(pe[4]));
    dubp_far_model far (.pin_out(po), .pin_oe(pe), .full(full),
                        .pin_lvl(pl), .cts_n(cts_n));

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (fifo_flush === 1'b1) flushes++;

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && k < 20)
        begin
            k++;
            @(posedge core_clk);
        end
        if (k >= 20)
        begin
            mismatches++;
            results();
        end
        q = avs_readdata;
        avs_write <= 0;
        avs_read  <= 0;
        @(posedge core_clk);
    endtask

    task automatic do_reset();
        rst <= 1;
        repeat (3) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset();
        bus(0, ADDR_CFG, 32'h0000_0000);
        chk(q, CFG_RESET);
        chk(pe, 5'h00);
        bus(0, ADDR_PINS, 32'h0000_0000);
        chk(q[4:0], 5'h1F);
        bus(0, ADDR_OTP_BASE + 8'h04, 32'h0000_0000);
        chk(q, {OTP_RELEASE, OTP_MAXPWR, OTP_ATTR});
        bus(0, ADDR_OTP_BASE + 8'h08, 32'h0000_0000);
        chk(q, 32'h3030_3030);
        bus(0, 8'h10, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("Test defaults done");
        enh_lvl <= 9'h0BF;
        std_lvl <= 9'h03E;
        repeat (3) @(posedge core_clk);
        chk(rts_n, 2'h0);
        bus(1, ADDR_CTRL, 32'h0000_0003);
        repeat (2) @(posedge core_clk);
        chk(rts_n, 2'h1);
        enh_lvl <= 9'h0BE;
        std_lvl <= 9'h03F;
        repeat (3) @(posedge core_clk);
        chk(rts_n, 2'h2);
        full <= 2'h1;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 2; i++)
        begin
            bs <= 2'h1;
            @(posedge core_clk);
            bs <= 2'h0;
            repeat (2) @(posedge core_clk);
            chk(halt, i);
        end
        full <= 2'h0;
        repeat (5) @(posedge core_clk);
        chk(halt, 2'h0);
        bus(1, ADDR_CTRL, 32'h0000_0007);
        repeat (3) @(posedge core_clk);
        chk(flushes, 1);
        $display("Test flow control done");
        bus(1, ADDR_CFG, 32'h0000_0129);
        bus(1, ADDR_LATCH, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        chk({pe, po}, {5'h17, 5'h00});
        bus(1, ADDR_LATCH, 32'h0000_001F);
        repeat (3) @(posedge core_clk);
        chk({pe, po & pe}, {5'h06, 5'h06});
        bus(1, ADDR_CFG, 32'h0000_0000);
        bus(0, ADDR_CFG, 32'h0000_0000);
        chk(q, 32'h0000_0129);
        bus(1, ADDR_LATCH, 32'h0000_0000);
        repeat (5) @(posedge core_clk);
        bus(0, ADDR_PINS, 32'h0000_0000);
        chk(q[4:0], 5'h08);
        $display("Test pin modes done");
        do_reset();
        bus(1, ADDR_CFG, 32'h0002_5000);
        repeat (3) @(posedge core_clk);
        chk({po[1:0], pe[1:0]}, 4'hF);
        act <= 5'h01;
        n = 0;
        @(posedge core_clk);
        prev = po[0];
        repeat (40)
        begin
            @(posedge core_clk);
            if (po[0] !== prev)
                n++;
            prev = po[0];
        end
        chk(po[1], 1'b0);
        chk(n >= 8 && n <= 12, 1'b1);
        act <= 5'h04;
        repeat (3) @(posedge core_clk);
        chk({po[1:0]}, 2'h1);
        $display("Test alternate functions done");
        do_reset();
        bus(1, ADDR_CFG, 32'h0005_86AA);
        bus(1, ADDR_CTRL, 32'h0000_0004);
        repeat (3) @(posedge core_clk);
        chk({pe, po}, {5'h1C, 5'h0C});
        chk(flushes, 1);
        act <= 5'h10;
        n = 0;
        prev = po[3];
        repeat (40)
        begin
            @(posedge core_clk);
            if (po[3] !== prev)
                n++;
            prev = po[3];
        end
        chk(n >= 8 && n <= 12, 1'b1);
        chk(po[2], 1'b1);
        $display("Test modem mode done");
        results();
    end
endmodule
`default_nettype wire
